// File: aed_pkg.sv
// package: constants for the axis encoder input and default parameter set
package aed_pkg;
	// ------------------------------------------------------------
	// default motion parameters
	// ------------------------------------------------------------
	localparam logic [15:0] AED_MAX_SPEED_HZ   = 16'h7FFF;
	localparam logic [15:0] AED_SET_SPEED_HZ   = 16'h03E8;
	localparam logic [15:0] AED_START_SPEED_HZ = 16'h00C8;
	localparam logic [15:0] AED_SAFETY_STEPS   = 16'h000A;
	localparam logic [15:0] AED_ACCEL_HZ_MS    = 16'h000A;
	localparam logic [5:0]  AED_EVAL_ALL       = 6'h3F;
	localparam logic [15:0] AED_POS_NUM        = 16'h0001;
	localparam logic [15:0] AED_SPD_NUM        = 16'h0100;
	localparam logic [15:0] AED_ACC_NUM        = 16'h03E8;
	localparam logic [15:0] AED_GEAR_NUM       = 16'h0000;
	localparam logic [15:0] AED_ENC_NUM        = 16'h0001;
	localparam logic [15:0] AED_DEN_ONE        = 16'h0001;
	localparam logic [6:0]  AED_CUR_STAND_PCT  = 7'h32;
	localparam logic [6:0]  AED_CUR_ACCEL_PCT  = 7'h64;
	localparam logic [6:0]  AED_CUR_RUN_PCT    = 7'h50;
	localparam logic [15:0] AED_CONTOUR_LIMIT  = 16'h0012;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [3:0] AED_REG_CTRL   = 4'h0;
	localparam logic [3:0] AED_REG_STATUS = 4'h1;
	localparam logic [3:0] AED_REG_MASK   = 4'h2;
	localparam logic [3:0] AED_REG_POS    = 4'h3;
	localparam logic [3:0] AED_REG_ERRCNT = 4'h4;
	// ctrl fields: bit0 signal type (1 pulse/dir), bit1 encoder connected
	localparam int AED_CTRL_PDIR = 0;
	localparam int AED_CTRL_CONN = 1;
	// status / mask fields
	localparam int AED_ST_CABLE  = 0;
	localparam int AED_ST_LINE   = 1;
	localparam int AED_ST_W      = 2;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		AED_MODE_PTP,
		AED_MODE_SPEED,
		AED_MODE_GEAR
	} aed_axis_mode_t;
	typedef enum logic [1:0] {
		AED_CUR_STAND,
		AED_CUR_ACCEL,
		AED_CUR_RUN
	} aed_cur_phase_t;
endpackage : aed_pkg

// File: aed_sync.sv
// module: two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/10ps
module aed_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta_q;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_q <= '0;
			o_q    <= '0;
		end else begin
			meta_q <= i_d;
			o_q    <= meta_q;
		end
	end
endmodule : aed_sync

// File: aed_axis_encoder_defaults.sv
// module: encoder input stage and power-on default parameter set of one axis
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/10ps
module aed_axis_encoder_defaults
	import aed_pkg::*;
#(
	parameter int POS_W = 32
) (
	input  wire logic                 i_clk,
	input  wire logic                 i_rst_n,
	input  wire logic                 i_prog_start,
	input  wire logic                 i_enc_a,
	input  wire logic                 i_enc_a_n,
	input  wire logic                 i_enc_b,
	input  wire logic                 i_enc_b_n,
	input  wire logic                 i_cable_check_input,
	input  wire logic [3:0]           i_addr,
	input  wire logic [31:0]          i_wdata,
	input  wire logic                 i_wr,
	input  wire logic                 i_rd,
	output logic      [31:0]          o_rdata,
	output logic                      o_irq,
	output logic                      o_cable_error,
	output logic      [POS_W-1:0]     o_enc_pos,
	output aed_axis_mode_t            o_axis_mode,
	output logic                      o_pos_defined,
	output logic      [15:0]          o_max_speed,
	output logic      [15:0]          o_set_speed,
	output logic      [15:0]          o_start_speed,
	output logic      [15:0]          o_safety_dist,
	output logic      [15:0]          o_accel,
	output logic      [5:0]           o_sig_eval,
	output logic      [15:0]          o_pos_num,
	output logic      [15:0]          o_pos_den,
	output logic      [15:0]          o_spd_num,
	output logic      [15:0]          o_spd_den,
	output logic      [15:0]          o_acc_num,
	output logic      [15:0]          o_acc_den,
	output logic      [15:0]          o_gear_num,
	output logic      [15:0]          o_gear_den,
	output logic      [15:0]          o_enc_num,
	output logic      [15:0]          o_enc_den,
	output logic      [6:0]           o_cur_stand,
	output logic      [6:0]           o_cur_accel,
	output logic      [6:0]           o_cur_run,
	output logic                      o_enc_connected,
	output logic                      o_enc_double_eval,
	output logic      [15:0]          o_contour_limit
);
	// ------------------------------------------------------------
	// pin synchronisation
	// ------------------------------------------------------------
	logic [4:0] pins_s;
	aed_sync #(
		.W (5)
	) u_sync (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_d     ({i_cable_check_input, i_enc_b_n, i_enc_b, i_enc_a_n, i_enc_a}),
		.o_q     (pins_s)
	);
	logic a_s, an_s, b_s, bn_s, chk_s;
	assign a_s   = pins_s[0];
	assign an_s  = pins_s[1];
	assign b_s   = pins_s[2];
	assign bn_s  = pins_s[3];
	assign chk_s = pins_s[4];

	// ------------------------------------------------------------
	// default parameter set
	// ------------------------------------------------------------
	logic load_def;
	logic first_q;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			first_q <= 1'b1;
		end else begin
			first_q <= 1'b0;
		end
	end
	assign load_def = first_q | i_prog_start;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_axis_mode   <= AED_MODE_PTP;
			o_pos_defined <= 1'b0;
			o_max_speed   <= AED_MAX_SPEED_HZ;
			o_set_speed   <= AED_SET_SPEED_HZ;
			o_start_speed <= AED_START_SPEED_HZ;
			o_accel       <= AED_ACCEL_HZ_MS;
		end else if (load_def) begin
			o_axis_mode   <= AED_MODE_PTP;
			o_pos_defined <= 1'b0;
			o_max_speed   <= AED_MAX_SPEED_HZ;
			o_set_speed   <= AED_SET_SPEED_HZ;
			o_start_speed <= AED_START_SPEED_HZ;
			o_accel       <= AED_ACCEL_HZ_MS;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_safety_dist <= AED_SAFETY_STEPS;
			o_sig_eval    <= AED_EVAL_ALL;
		end else if (load_def) begin
			o_safety_dist <= AED_SAFETY_STEPS;
			o_sig_eval    <= AED_EVAL_ALL;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pos_num  <= AED_POS_NUM;
			o_spd_num  <= AED_SPD_NUM;
			o_acc_num  <= AED_ACC_NUM;
			o_gear_num <= AED_GEAR_NUM;
			o_enc_num  <= AED_ENC_NUM;
			o_pos_den  <= AED_DEN_ONE;
			o_spd_den  <= AED_DEN_ONE;
			o_acc_den  <= AED_DEN_ONE;
			o_gear_den <= AED_DEN_ONE;
			o_enc_den  <= AED_DEN_ONE;
		end else if (load_def) begin
			o_pos_num  <= AED_POS_NUM;
			o_spd_num  <= AED_SPD_NUM;
			o_acc_num  <= AED_ACC_NUM;
			o_gear_num <= AED_GEAR_NUM;
			o_enc_num  <= AED_ENC_NUM;
			o_pos_den  <= AED_DEN_ONE;
			o_spd_den  <= AED_DEN_ONE;
			o_acc_den  <= AED_DEN_ONE;
			o_gear_den <= AED_DEN_ONE;
			o_enc_den  <= AED_DEN_ONE;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_cur_stand <= AED_CUR_STAND_PCT;
			o_cur_accel <= AED_CUR_ACCEL_PCT;
			o_cur_run   <= AED_CUR_RUN_PCT;
		end else if (load_def) begin
			o_cur_stand <= AED_CUR_STAND_PCT;
			o_cur_accel <= AED_CUR_ACCEL_PCT;
			o_cur_run   <= AED_CUR_RUN_PCT;
		end
	end

	// ------------------------------------------------------------
	// control register
	// ------------------------------------------------------------
	logic ctrl_pdir_q;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_pdir_q       <= 1'b0;
			o_enc_connected   <= 1'b0;
			o_enc_double_eval <= 1'b0;
			o_contour_limit   <= AED_CONTOUR_LIMIT;
		end else if (load_def) begin
			o_enc_connected   <= 1'b0;
			o_enc_double_eval <= 1'b0;
			o_contour_limit   <= AED_CONTOUR_LIMIT;
		end else if (i_wr && i_addr == AED_REG_CTRL) begin
			ctrl_pdir_q     <= i_wdata[AED_CTRL_PDIR];
			o_enc_connected <= i_wdata[AED_CTRL_CONN];
		end
	end

	// ------------------------------------------------------------
	// encoder decoding
	// ------------------------------------------------------------
	logic a_p_q, b_p_q;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			a_p_q <= 1'b0;
			b_p_q <= 1'b0;
		end else begin
			a_p_q <= a_s;
			b_p_q <= b_s;
		end
	end
	// a differential pair is valid only when the two lines disagree
	logic pair_ok;
	assign pair_ok = (a_s ^ an_s) & (b_s ^ bn_s);
	logic step_up, step_dn;
	always_comb begin
		step_up = 1'b0;
		step_dn = 1'b0;
		if (pair_ok && o_enc_connected) begin
			if (ctrl_pdir_q) begin
				// pulse counted on rising edge, b is direction
				if (a_s && !a_p_q) begin
					step_up = b_s;
					step_dn = !b_s;
				end
			end else if ((a_s ^ a_p_q) && !(b_s ^ b_p_q) && !b_s) begin
				// single evaluation, a edge with b low
				step_up = a_s;
				step_dn = !a_s;
			end
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_enc_pos <= '0;
		end else if (load_def) begin
			o_enc_pos <= '0;
		end else if (step_up) begin
			o_enc_pos <= o_enc_pos + POS_W'(1);
		end else if (step_dn) begin
			o_enc_pos <= o_enc_pos - POS_W'(1);
		end
	end

	// ------------------------------------------------------------
	// cable check and events
	// ------------------------------------------------------------
	logic cable_ev, line_ev, chk_p_q;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			chk_p_q       <= 1'b1;
			o_cable_error <= 1'b0;
		end else begin
			chk_p_q       <= chk_s;
			o_cable_error <= o_enc_connected & ~chk_s;
		end
	end
	assign cable_ev = o_enc_connected & chk_p_q & ~chk_s;
	assign line_ev  = o_enc_connected & ~pair_ok;

	logic [AED_ST_W-1:0] status_q, mask_q;
	logic [15:0]         errcnt_q;
	logic                rd_status;
	assign rd_status = i_rd && i_addr == AED_REG_STATUS;
	// set wins over read clear
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			status_q <= '0;
		end else begin
			status_q <= (rd_status ? '0 : status_q) | {line_ev, cable_ev};
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mask_q <= '0;
		end else if (i_wr && i_addr == AED_REG_MASK) begin
			mask_q <= i_wdata[AED_ST_W-1:0];
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			errcnt_q <= '0;
		end else if (cable_ev && errcnt_q != 16'hFFFF) begin
			errcnt_q <= errcnt_q + 16'h0001;
		end
	end
	assign o_irq = |(status_q & mask_q);

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= '0;
		end else if (i_rd) begin
			case (i_addr)
				AED_REG_CTRL:   o_rdata <= {30'h0, o_enc_connected, ctrl_pdir_q};
				AED_REG_STATUS: o_rdata <= {30'h0, status_q};
				AED_REG_MASK:   o_rdata <= {30'h0, mask_q};
				AED_REG_POS:    o_rdata <= 32'(o_enc_pos);
				AED_REG_ERRCNT: o_rdata <= {16'h0, errcnt_q};
				default:        o_rdata <= '0;
			endcase
		end else begin
			o_rdata <= '0;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	property p_start_defaults;
		@(posedge i_clk) disable iff (!i_rst_n)
		i_prog_start |=> (o_set_speed == AED_SET_SPEED_HZ && o_start_speed == AED_START_SPEED_HZ
			&& o_max_speed == AED_MAX_SPEED_HZ && !o_pos_defined);
	endproperty
	a_start_defaults: assert property (p_start_defaults) else $error("speed defaults");
	property p_safety;
		@(posedge i_clk) disable iff (!i_rst_n)
		i_prog_start |=> o_safety_dist == AED_SAFETY_STEPS && o_sig_eval == AED_EVAL_ALL;
	endproperty
	a_safety: assert property (p_safety) else $error("safety or eval default");
	property p_factors;
		@(posedge i_clk) disable iff (!i_rst_n)
		i_prog_start |=> o_spd_num == AED_SPD_NUM && o_acc_num == AED_ACC_NUM
			&& o_gear_num == AED_GEAR_NUM && o_pos_num == AED_POS_NUM;
	endproperty
	a_factors: assert property (p_factors) else $error("factor defaults");
	property p_current;
		@(posedge i_clk) disable iff (!i_rst_n)
		i_prog_start |=> o_cur_stand == AED_CUR_STAND_PCT && o_cur_run == AED_CUR_RUN_PCT;
	endproperty
	a_current: assert property (p_current) else $error("current defaults");
	property p_enc_def;
		@(posedge i_clk) disable iff (!i_rst_n)
		i_prog_start |=> !o_enc_connected && o_contour_limit == AED_CONTOUR_LIMIT;
	endproperty
	a_enc_def: assert property (p_enc_def) else $error("encoder defaults");
	property p_cable;
		@(posedge i_clk) disable iff (!i_rst_n)
		cable_ev |=> status_q[AED_ST_CABLE] && o_cable_error;
	endproperty
	a_cable: assert property (p_cable) else $error("cable loss not flagged");
	property p_count_up;
		@(posedge i_clk) disable iff (!i_rst_n)
		(step_up && !load_def) |=> o_enc_pos == $past(o_enc_pos) + POS_W'(1);
	endproperty
	a_count_up: assert property (p_count_up) else $error("count up wrong");
	property p_idle;
		@(posedge i_clk) disable iff (!i_rst_n)
		(!o_enc_connected && !load_def) |=> $stable(o_enc_pos);
	endproperty
	a_idle: assert property (p_idle) else $error("count while disconnected");
	property p_irq;
		@(posedge i_clk) disable iff (!i_rst_n)
		(rd_status && !cable_ev && !line_ev) |=> !o_irq;
	endproperty
	a_irq: assert property (p_irq) else $error("irq not cleared by status read");
	c_cable: cover property (@(posedge i_clk) cable_ev);
	c_up:    cover property (@(posedge i_clk) step_up);
	c_dn:    cover property (@(posedge i_clk) step_dn);
	c_start: cover property (@(posedge i_clk) i_prog_start);
endmodule : aed_axis_encoder_defaults

// File: aed_enc_model.sv
// file: behavioural incremental encoder with complement pins and cable loop-back
`timescale 1ns/10ps
module aed_enc_model (
	input  wire logic i_clk,
	output logic      o_a,
	output logic      o_a_n,
	output logic      o_b,
	output logic      o_b_n,
	output logic      o_cable
);
	logic a_q;
	logic b_q;
	logic brk_q;
	logic cab_q;
	initial begin
		a_q = 1'b0;
		b_q = 1'b0;
		brk_q = 1'b0;
		cab_q = 1'b1;
	end
	assign o_a   = a_q;
	assign o_a_n = brk_q ? a_q : ~a_q;
	assign o_b   = b_q;
	assign o_b_n = ~b_q;
	assign o_cable = cab_q;
	task automatic pin(input logic a, input logic b);
		@(posedge i_clk);
		a_q <= a;
		b_q <= b;
		repeat (4) @(posedge i_clk);
	endtask : pin
	// quadrature, one full cycle, a leads forward
	task automatic quad(input bit fwd);
		pin(fwd, ~fwd);
		pin(1'b1, 1'b1);
		pin(~fwd, fwd);
		pin(1'b0, 1'b0);
	endtask : quad
	// pulse on a, direction level on b
	task automatic pulse(input bit fwd);
		pin(1'b0, fwd);
		pin(1'b1, fwd);
		pin(1'b0, fwd);
	endtask : pulse
endmodule : aed_enc_model

// File: tb.sv
// file: self-checking testbench for the axis encoder stage and default set
`timescale 1ns/10ps
module tb;
	import aed_pkg::*;
	logic           i_clk, i_rst_n, i_prog_start, i_wr, i_rd;
	logic [3:0]     i_addr;
	logic [31:0]    i_wdata, o_rdata;
	logic           enc_a, enc_a_n, enc_b, enc_b_n, enc_cable;
	logic           o_irq, o_cable_error, o_pos_defined, o_enc_connected, o_enc_double_eval;
	logic [31:0]    o_enc_pos;
	aed_axis_mode_t o_axis_mode;
	logic [15:0]    o_max_speed, o_set_speed, o_start_speed, o_safety_dist, o_accel;
	logic [15:0]    o_pos_num, o_pos_den, o_spd_num, o_spd_den, o_acc_num, o_acc_den;
	logic [15:0]    o_gear_num, o_gear_den, o_enc_num, o_enc_den, o_contour_limit;
	logic [6:0]     o_cur_stand, o_cur_accel, o_cur_run;
	logic [5:0]     o_sig_eval;
	int             err_count, n_tests, cyc;

	aed_enc_model enc_u (.i_clk(i_clk), .o_a(enc_a), .o_a_n(enc_a_n), .o_b(enc_b),
		.o_b_n(enc_b_n), .o_cable(enc_cable));

	aed_axis_encoder_defaults #(.POS_W(32)) dut_u (
		.i_clk, .i_rst_n, .i_prog_start, .i_enc_a(enc_a), .i_enc_a_n(enc_a_n),
		.i_enc_b(enc_b), .i_enc_b_n(enc_b_n), .i_cable_check_input(enc_cable),
		.i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_irq, .o_cable_error, .o_enc_pos,
		.o_axis_mode, .o_pos_defined, .o_max_speed, .o_set_speed, .o_start_speed,
		.o_safety_dist, .o_accel, .o_sig_eval, .o_pos_num, .o_pos_den, .o_spd_num,
		.o_spd_den, .o_acc_num, .o_acc_den, .o_gear_num, .o_gear_den, .o_enc_num,
		.o_enc_den, .o_cur_stand, .o_cur_accel, .o_cur_run, .o_enc_connected,
		.o_enc_double_eval, .o_contour_limit);

	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end

	task automatic complete_run();
		if (err_count == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : complete_run

	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			err_count++;
			complete_run();
		end
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [31:0] next_pos(input logic [31:0] p, input bit fwd);
		return fwd ? p + 32'h1 : p - 32'h1;
	endfunction : next_pos

	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask : reg_rd

	task automatic check_defaults();
		chk({o_axis_mode, o_pos_defined, o_enc_pos}, 35'h0);
		chk({o_max_speed, o_set_speed, o_start_speed}, 48'h7FFF_03E8_00C8);
		chk(o_accel, 16'h000A);
		chk(o_safety_dist, 16'h000A);
		chk(o_sig_eval, 6'h3F);
		chk({o_pos_num, o_pos_den}, 32'h0001_0001);
		chk({o_spd_num, o_spd_den}, 32'h0100_0001);
		chk({o_acc_num, o_acc_den}, 32'h03E8_0001);
		chk({o_gear_num, o_gear_den}, 32'h0000_0001);
		chk({o_enc_num, o_enc_den}, 32'h0001_0001);
		chk({1'b0, o_cur_stand, 1'b0, o_cur_accel, 1'b0, o_cur_run}, 24'h326450);
		chk({o_enc_connected, o_enc_double_eval, o_contour_limit}, 18'h00012);
	endtask : check_defaults

	// drop or restore the loop-back line, let the synchroniser settle
	task automatic cable(input logic lvl);
		@(posedge i_clk);
		enc_u.cab_q <= lvl;
		repeat (6) @(posedge i_clk);
		#1;
	endtask : cable

	initial begin
		logic [31:0] rd;
		logic [31:0] pos_exp;
		bit          fwd;
		err_count = 0;
		n_tests = 0;
		cyc = 0;
		i_rst_n = 1'b0;
		i_prog_start = 1'b0;
		i_addr = 4'h0;
		i_wdata = 32'h0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		pos_exp = 32'h0;
		void'($urandom(32'h437A));
		repeat (12) @(posedge i_clk);
		i_rst_n <= 1'b1;
		repeat (2) @(posedge i_clk);
		#1 check_defaults();
		reg_rd(4'hF, rd);
		chk(rd, 32'h0);
		// quadrature counting, random directions
		reg_wr(AED_REG_CTRL, 32'h2);
		for (int k = 0; k < 10; k++) begin
			fwd = $urandom % 2;
			enc_u.quad(fwd);
			pos_exp = next_pos(pos_exp, fwd);
			#1 chk(o_enc_pos, pos_exp);
		end
		// pulse/direction counting
		reg_wr(AED_REG_CTRL, 32'h3);
		for (int k = 0; k < 10; k++) begin
			fwd = $urandom % 2;
			enc_u.pulse(fwd);
			pos_exp = next_pos(pos_exp, fwd);
			#1 chk(o_enc_pos, pos_exp);
		end
		reg_rd(AED_REG_POS, rd);
		chk(rd, pos_exp);
		// cable loss while masked, then unmasked
		reg_wr(AED_REG_MASK, 32'h0);
		cable(1'b0);
		chk({o_cable_error, o_irq}, 2'h2);
		reg_rd(AED_REG_STATUS, rd);
		chk(rd[1:0], 2'h1);
		reg_rd(AED_REG_STATUS, rd);
		chk(rd[1:0], 2'h0);
		cable(1'b1);
		chk(o_cable_error, 1'b0);
		reg_wr(AED_REG_MASK, 32'h1);
		cable(1'b0);
		chk({o_cable_error, o_irq}, 2'h3);
		reg_rd(AED_REG_STATUS, rd);
		chk({rd[1:0], o_irq}, 3'h2);
		reg_rd(AED_REG_ERRCNT, rd);
		chk(rd, 32'h2);
		cable(1'b1);
		// broken complement pair: no count, line event
		reg_wr(AED_REG_MASK, 32'h3);
		@(posedge i_clk);
		enc_u.brk_q <= 1'b1;
		enc_u.pulse(1'b1);
		#1 chk({o_enc_pos, o_irq}, {pos_exp, 1'b1});
		reg_rd(AED_REG_STATUS, rd);
		chk(rd[1], 1'b1);
		enc_u.brk_q <= 1'b0;
		// program start reloads defaults, counting stops
		@(posedge i_clk);
		i_prog_start <= 1'b1;
		@(posedge i_clk);
		i_prog_start <= 1'b0;
		repeat (2) @(posedge i_clk);
		#1 check_defaults();
		enc_u.pulse(1'b1);
		#1 chk(o_enc_pos, 32'h0);
		complete_run();
	end
endmodule : tb
